// [bench/ncda_core_assertions.sv]
// port checks bound onto the ncda core
`timescale 1ns/100ps
`default_nettype none
module ncda_core_checker
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core
    input wire logic machine_cycle
);
    import ncda_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // bus and cycle checks
    // ------------------------------------------------------------
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    AST_WR_RESP: assert property (wr_take |=> s_axi_bvalid) else $error("write taken without response");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_R_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read without data");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_AR_STALL: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    AST_AW_STALL: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr > ncda_off_alt ||
        s_axi_araddr[1:0] != 2'h0) |=> s_axi_rresp == ncda_resp_slverr && s_axi_rdata == 32'h0) else $error("bad read");
    AST_CYCLE_LIVE: assert property (1'b1 |-> ##[0:65] machine_cycle) else $error("machine cycle missing");
endmodule : ncda_core_checker
bind ncda_core ncda_core_checker ncda_core_checker_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .machine_cycle);
`default_nettype wire

// [bench/ncda_dmem_model.sv]
// data memory stand-in feeding the hl load
`timescale 1ns/100ps
`default_nettype none
module ncda_dmem_model
#(
    parameter logic [3:0] fill = 4'ha
)
(
    // read data
    output logic [3:0] dmem_rdata
);
    // no address leaves the core, so one fixed nibble stands for the cell
    assign dmem_rdata = fill;
endmodule : ncda_dmem_model
`default_nettype wire

// [bench/tb_ncda_core.sv]
// register-level bench for the ncda core
`timescale 1ns/100ps
`default_nettype none
module tb_ncda_core;
    import ncda_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, machine_cycle;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0] dmem_rdata;
    int n_fail = 0, checked = 0, p;
    ncda_core ncda_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dmem_rdata,
        .machine_cycle);
    ncda_dmem_model ncda_dmem_model_inst (.dmem_rdata);
    initial
    begin
        forever #2.5 aclk = ~aclk;
    end
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task close_out(input bit hung);
        if (hung)
            n_fail++;
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // ready is looked at mid-cycle, the transfer then happens at the next rising edge
    task hs(input int s);
        int i;
        for (i = 0; i < 200; i++)
        begin
            @(negedge aclk);
            if ((s == 0 ? s_axi_awready && s_axi_wready : s == 1 ? s_axi_bvalid : s == 2 ? s_axi_arready :
                s_axi_rvalid) === 1'b1)
                break;
        end
        if (i == 200)
            close_out(1'b1);
        got = s_axi_rdata;
        rsp = (s == 1) ? s_axi_bresp : s_axi_rresp;
        @(posedge aclk);
    endtask : hs
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hs(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        hs(1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hs(2);
        s_axi_arvalid <= 1'b0;
        hs(3);
        s_axi_rready <= 1'b0;
    endtask : rd
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task op(input logic [31:0] w, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wr(ncda_off_pc, 32'h0000_2345);
        wr(ncda_off_op, w);
        rd(a);
        chk(got & m, e);
    endtask : op
    task mcnt(input logic [31:0] c, input int n, input int e);
        int k;
        wr(ncda_off_ctrl, c);
        k = 0;
        repeat (n)
        begin
            @(negedge aclk);
            k += machine_cycle;
        end
        chk(k, e);
    endtask : mcnt
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ncda_off_ctrl);
        chk(got, 32'h0000_0800);
        rd(8'h40);
        chk({30'h0, rsp}, {30'h0, ncda_resp_slverr});
        wr(8'h40, 32'h0);
        chk({30'h0, rsp}, {30'h0, ncda_resp_slverr});
        wr(ncda_off_regs, 32'h6077_0e05);
        wr(ncda_off_alt, 32'h4433_2211);
        wr(ncda_off_stat, 32'h0);
        op(32'h0000_9001, ncda_off_mem, 32'hffff, 32'hff90);
        op(32'h0000_9001, ncda_off_stat, 32'h20, 32'h20);
        op(32'h0000_1001, ncda_off_mem, 32'hffff, 32'h0010);
        op(32'h0002_1302, ncda_off_mem, 32'h3ffff, 32'h2fff3);
        op(32'h0000_0502, ncda_off_mem, 32'h3ffff, 32'h0ffb5);
        op(32'h0000_f003, ncda_off_mem, 32'h3ffff, 32'h2fff1);
        op(32'h0100_0004, ncda_off_pc, 32'h3fff0000, 32'h2344_0000);
        op(32'h0f00_0004, ncda_off_pc, 32'h3fff0000, 32'h2336_0000);
        op(32'h1000_0004, ncda_off_pc, 32'h3fff0000, 32'h2347_0000);
        op(32'h1e00_0004, ncda_off_pc, 32'h3fff0000, 32'h2355_0000);
        op(32'h000a_bc05, ncda_off_pc, 32'h3fff0000, 32'h2abc_0000);
        op(32'h003f_ff06, ncda_off_pc, 32'h3fff0000, 32'h07ff_0000);
        op(32'h0000_2107, ncda_off_stat, 32'h8, 32'h8);
        op(32'h0000_1e07, ncda_off_stat, 32'h8, 32'h8);
        op(32'h0000_4007, ncda_off_stat, 32'h8, 32'h0);
        op(32'h0000_0009, ncda_off_pc, 32'h3fff0000, 32'h2377_0000);
        op(32'h0000_000a, ncda_off_pc, 32'h3fff0000, 32'h2305_0000);
        op(32'h0000_000b, ncda_off_mem, 32'hfffc0000, 32'h81dc_0000);
        op(32'h0000_0510, ncda_off_stat, 32'h7, 32'h3);
        op(32'h0000_0910, ncda_off_stat, 32'h7, 32'h3);
        op(32'h0000_0b10, ncda_off_stat, 32'h7, 32'h3);
        op(32'h0000_0d10, ncda_off_stat, 32'h7, 32'h5);
        $display("addressing tests done");
        op(32'h0012_3408, ncda_off_stat, 32'h8, 32'h8);
        wr(ncda_off_ctrl, 32'h0);
        op(32'h0012_3408, ncda_off_pc, 32'h3fff0000, 32'h1234_0000);
        op(32'h0000_000c, ncda_off_stat, 32'h100, 32'h100);
        rd(ncda_off_regs);
        chk(got & 32'hf, 32'h2);
        op(32'h0000_010d, ncda_off_regs, 32'hff, 32'h11);
        rd(ncda_off_stat);
        chk(got & 32'h100, 32'h0);
        for (p = 4; p < 8; p++)
            op(32'h0f | (p << 8), ncda_off_stat, 32'hff0000, (p - 3) * 32'h110000);
        wr(ncda_off_regs, 32'hf077_0e05);
        op(32'h0000_000e, ncda_off_regs, 32'hf000000f, 32'h0000_000a);
        rd(ncda_off_stat);
        chk(got & 32'h1, 32'h1);
        op(32'h0000_1211, ncda_off_mem, 32'hffff, 32'h0012);
        $display("operation tests done");
        wr(ncda_off_ctrl, 32'h0000_0911);
        op(32'h0000_ec01, ncda_off_mem, 32'hffff, 32'h11ec);
        rd(ncda_off_stat);
        chk(got & 32'h50, 32'h50);
        wr(ncda_off_ctrl, 32'h0000_081f);
        op(32'h0000_1001, ncda_off_mem, 32'hffff, 32'hff10);
        mcnt(32'h0000_3800, 16, 16);
        mcnt(32'h0000_1800, 64, 4);
        mcnt(32'h0000_0800, 128, 2);
        $display("bank and cycle tests done");
        close_out(1'b0);
    end
endmodule : tb_ncda_core
`default_nettype wire

// [verilog/ncda_core.sv]
// decode and operand addressing core with axi4-lite register access
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - display buffer 1ECH-1F7H, peripherals from F80H
// - stack lives in bank 0 or 1
// - bank flag clear: low 0, high 15
// - short bit operands only FB0-FBF, FF0-FFF bank 15
// - indexed bit: operand 5-2 plus L 3-2
// - relative branch reaches -15..-1 and +2..+16
// - page branch keeps PC bits 13-12
// - fast call target zero-extended 11 bits
// - table operand 20H-7FH, even only
// - long 14-bit targets only in extended mode
// - indirect branch replaces PC low byte only
// - met skip costs one extra cycle, two when length is 3
// - skipped table-indirect costs one cycle
// - machine cycle from four clock choices
// - table read uses B low two bits
// - rotate: A0 to carry, carry to A3
// - pair select covers main and expansion pairs
// - reset starts in basic compatibility mode
module ncda_core
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // data memory read port for the load via hl
    input wire logic [3:0] dmem_rdata,
    // machine cycle strobe
    output logic machine_cycle
);
    import ncda_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0] bank_select_reg;
        logic bank_enable_flag;
        logic [3:0] stack_bank_reg;
        logic [1:0] cpu_clock_control_reg;
        logic regbank_enable_flag;
        logic [1:0] regbank_select_reg;
        logic [31:0] regs;    // x a b c d e h l nibbles, a in 3:0
        logic [31:0] alt;     // expansion pairs xa' bc' de' hl'
        logic carry_flag;
        logic [13:0] pc;
        logic [13:0] pc_next_out;
        logic [3:0] mem_bank;
        logic [11:0] mem_addr;
        logic [1:0] mem_bit;
        logic [13:0] rom_addr;
        logic skip;
        logic [1:0] skip_cycles;
        logic op_error;
        logic disp_hit;
        logic periph_hit;
        logic stack_bank;
        logic [7:0] pair_out;
        logic [7:0] cyc_cnt;
        logic cyc_pulse;
    } ncda_state_type;

    ncda_state_type st;
    ncda_state_type next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] ncda_nib(input logic [31:0] r, input int idx);
        ncda_nib = r[idx*4 +: 4];
    endfunction : ncda_nib

    // pair index: 0 xa, 1 bc, 2 de, 3 hl, 4..7 expansion set
    function automatic logic [7:0] ncda_pair(input logic [31:0] r, input logic [31:0] a,
                                              input logic [2:0] sel);
        logic [31:0] src;
        src = sel[2] ? a : r;
        ncda_pair = src[sel[1:0]*8 +: 8];
    endfunction : ncda_pair

    function automatic logic [3:0] ncda_direct_bank(input logic bank_enable_flag, input logic [3:0] bank_select_reg,
                                                     input logic [7:0] mem);
        if (!bank_enable_flag)
            ncda_direct_bank = mem[7] ? ncda_bank_periph : 4'h0;
        else if (bank_select_reg == 4'h0 || bank_select_reg == 4'h1 || bank_select_reg == ncda_bank_periph)
            ncda_direct_bank = bank_select_reg;
        else
            ncda_direct_bank = 4'h0;
    endfunction : ncda_direct_bank

    logic aw_fire;
    logic w_fire;
    logic do_write;
    logic do_read;
    logic ext_mode;
    ncda_cmd_type cmd;
    logic [13:0] opnd;
    logic [4:0] rel_off;
    logic [31:0] wdat;
    logic [8:0] add9;
    logic [3:0] reg_a;
    logic [3:0] reg_l;
    logic [11:0] full_addr;
    logic [7:0] cyc_div;

    assign ext_mode = ~st.stack_bank_reg[ncda_sbs_mode_bit];
    assign s_axi_awready = ~st.aw_held & ~st.bvalid;
    assign s_axi_wready = ~st.w_held & ~st.bvalid;
    assign s_axi_arready = ~st.rvalid;
    assign aw_fire = s_axi_awvalid & s_axi_awready;
    assign w_fire = s_axi_wvalid & s_axi_wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign machine_cycle = st.cyc_pulse;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        do_write = (st.aw_held | aw_fire) & (st.w_held | w_fire) & ~st.bvalid;
        do_read = s_axi_arvalid & ~st.rvalid;
        cmd = ncda_cmd_type'(s_axi_wdata[4:0]);
        opnd = s_axi_wdata[21:8];
        rel_off = s_axi_wdata[28:24];
        reg_a = ncda_nib(st.regs, 0);
        reg_l = ncda_nib(st.regs, 7);
        wdat = st.w_held ? st.w_data : s_axi_wdata;
        add9 = 9'h000;
        full_addr = 12'h000;

        if (aw_fire)
        begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (w_fire)
        begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end

        // machine cycle divider selected by clock control
        case (st.cpu_clock_control_reg)
            2'd0: cyc_div = ncda_pcc_div0;
            2'd1: cyc_div = ncda_pcc_div1;
            2'd2: cyc_div = ncda_pcc_div2;
            default: cyc_div = ncda_pcc_div3;
        endcase
        if (st.cyc_cnt + 8'h01 >= cyc_div)
        begin
            next_st.cyc_cnt = 8'h00;
            next_st.cyc_pulse = 1'b1;
        end
        else
        begin
            next_st.cyc_cnt = st.cyc_cnt + 8'h01;
            next_st.cyc_pulse = 1'b0;
        end
        next_st.stack_bank = st.stack_bank_reg[0];

        if (do_write)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = ncda_resp_okay;
            // use the latched beats when earlier, else the live ones
            cmd = ncda_cmd_type'(wdat[4:0]);
            opnd = wdat[21:8];
            rel_off = wdat[28:24];
            case (st.aw_held ? st.aw_addr : s_axi_awaddr)
                ncda_off_ctrl:
                begin
                    next_st.bank_select_reg = wdat[ncda_ctrl_mbs_lsb +: 4];
                    next_st.bank_enable_flag = wdat[ncda_ctrl_mbe];
                    next_st.stack_bank_reg = wdat[ncda_ctrl_sbs_lsb +: 4];
                    next_st.cpu_clock_control_reg = wdat[ncda_ctrl_pcc_lsb +: 2];
                    next_st.regbank_enable_flag = wdat[ncda_ctrl_rbe];
                    next_st.regbank_select_reg = wdat[ncda_ctrl_rbs_lsb +: 2];
                end
                ncda_off_regs: next_st.regs = wdat;
                ncda_off_alt: next_st.alt = wdat;
                ncda_off_pc: next_st.pc = wdat[13:0];
                ncda_off_stat: next_st.carry_flag = wdat[0];
                ncda_off_op:
                begin
                    next_st.skip = 1'b0;
                    next_st.skip_cycles = 2'd0;
                    next_st.op_error = 1'b0;
                    next_st.pc_next_out = st.pc;
                    case (cmd)
                        ncda_cmd_direct:
                        begin
                            full_addr = {opnd[7] ? 4'hf : 4'h0, opnd[7:0]};
                            next_st.mem_bank = ncda_direct_bank(st.bank_enable_flag, st.bank_select_reg, opnd[7:0]);
                            next_st.mem_addr = st.bank_enable_flag ? {next_st.mem_bank, opnd[7:0]} : full_addr;
                        end
                        ncda_cmd_word_access:
                        begin
                            // pair access always starts at the even nibble
                            next_st.mem_bank = ncda_direct_bank(st.bank_enable_flag, st.bank_select_reg, opnd[7:0]);
                            next_st.mem_addr = {next_st.mem_bank, opnd[7:1], 1'b0};
                            next_st.op_error = opnd[0];
                        end
                        ncda_cmd_fmem:
                        begin
                            next_st.mem_bank = ncda_bank_periph;
                            next_st.mem_addr = (opnd[4] ? ncda_fmem_b_lo : ncda_fmem_a_lo) | {8'h00, opnd[3:0]};
                            next_st.mem_bit = opnd[9:8];
                        end
                        ncda_cmd_pmem:
                        begin
                            next_st.mem_bank = ncda_bank_periph;
                            next_st.mem_addr = {4'hf, 2'b11, opnd[5:2], reg_l[3:2]};
                            next_st.mem_bit = reg_l[1:0];
                        end
                        ncda_cmd_rel:
                        begin
                            // offsets 1..15 step back, 16..30 map to +2..+16
                            if (rel_off == 5'd0 || rel_off == 5'd31)
                                next_st.op_error = 1'b1;
                            else if (rel_off <= 5'(ncda_rel_back_max))
                                next_st.pc_next_out = st.pc - {9'h000, rel_off};
                            else
                                next_st.pc_next_out = st.pc + 14'(rel_off - 5'(ncda_rel_back_max)
                                                      + 5'(ncda_rel_fwd_min) - 5'd1);
                        end
                        ncda_cmd_page_branch:
                            next_st.pc_next_out = {st.pc[13:12], opnd[11:0]};
                        ncda_cmd_fast_call:
                            next_st.pc_next_out = {3'b000, opnd[10:0]};
                        ncda_cmd_table_indirect:
                        begin
                            if (opnd[7:0] < ncda_taddr_lo || opnd[7:0] > ncda_taddr_hi || opnd[0])
                                next_st.op_error = 1'b1;
                            else
                                next_st.rom_addr = {6'h00, opnd[7:0]};
                        end
                        ncda_cmd_long_branch:
                        begin
                            if (ext_mode)
                                next_st.pc_next_out = opnd;
                            else
                                next_st.op_error = 1'b1;
                        end
                        ncda_cmd_br_de:
                            next_st.pc_next_out = {st.pc[13:8], ncda_pair(st.regs, st.alt, 3'd2)};
                        ncda_cmd_br_xa:
                            next_st.pc_next_out = {st.pc[13:8], ncda_pair(st.regs, st.alt, 3'd0)};
                        ncda_cmd_table_read:
                            next_st.rom_addr = {st.regs[9:8], ncda_nib(st.regs, 3),
                                                ncda_pair(st.regs, st.alt, 3'd2)};
                        ncda_cmd_rotate_carry:
                        begin
                            next_st.carry_flag = reg_a[0];
                            next_st.regs[3:0] = {st.carry_flag, reg_a[3:1]};
                        end
                        ncda_cmd_add_with_carry:
                        begin
                            add9 = {1'b0, st.regs[7:0]} + {1'b0, ncda_pair(st.regs, st.alt, opnd[2:0])}
                                   + {8'h00, st.carry_flag};
                            next_st.regs[7:0] = add9[7:0];
                            next_st.carry_flag = add9[8];
                        end
                        ncda_cmd_ld_hl_inc:
                        begin
                            next_st.mem_addr = {4'h0, ncda_pair(st.regs, st.alt, 3'd3)};
                            next_st.regs[3:0] = dmem_rdata;
                            next_st.regs[31:28] = reg_l + 4'h1;
                            next_st.skip = (reg_l == 4'hf);
                            next_st.skip_cycles = (reg_l == 4'hf) ? 2'd1 : 2'd0;
                        end
                        ncda_cmd_pair_read:
                            next_st.pair_out = ncda_pair(st.regs, st.alt, opnd[2:0]);
                        ncda_cmd_skip:
                        begin
                            // opnd bit 0 condition met, bit 1 next is table-indirect, bits 3:2 length
                            next_st.skip = opnd[0];
                            if (!opnd[0])
                                next_st.skip_cycles = 2'd0;
                            else if (opnd[1])
                                next_st.skip_cycles = 2'd1;
                            else if (opnd[3:2] <= 2'd2)
                                next_st.skip_cycles = 2'd1;
                            else
                                next_st.skip_cycles = 2'd2;
                        end
                        default: next_st.op_error = (cmd != ncda_cmd_nop);
                    endcase
                    next_st.disp_hit = (next_st.mem_addr >= ncda_disp_lo)
                                       && (next_st.mem_addr <= ncda_disp_hi);
                    next_st.periph_hit = (next_st.mem_addr >= ncda_periph_lo);
                end
                default: next_st.bresp = ncda_resp_slverr;
            endcase
        end
        else if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;

        if (do_read)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = ncda_resp_okay;
            case (s_axi_araddr)
                ncda_off_ctrl: next_st.rdata = {13'h0000, st.regbank_select_reg, st.regbank_enable_flag, 2'b00, st.cpu_clock_control_reg,
                                                st.stack_bank_reg, 3'b000, st.bank_enable_flag, st.bank_select_reg};
                ncda_off_regs: next_st.rdata = st.regs;
                ncda_off_alt: next_st.rdata = st.alt;
                ncda_off_pc: next_st.rdata = {2'b00, st.pc_next_out, 2'b00, st.pc};
                ncda_off_mem: next_st.rdata = {st.rom_addr, st.mem_bit, st.mem_bank, st.mem_addr};
                ncda_off_stat: next_st.rdata = {8'h00, st.pair_out, 7'h00, st.carry_flag, 1'b0, st.stack_bank,
                                                st.periph_hit, st.disp_hit, st.op_error, st.skip_cycles, st.skip};
                default:
                begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = ncda_resp_slverr;
                end
            endcase
        end
        else if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= '0;
            st.stack_bank_reg <= ncda_sbs_reset;
            st.bank_select_reg <= ncda_mbs_reset;
        end
        else
            st <= next_st;
    end

endmodule : ncda_core

`default_nettype wire

// [verilog/ncda_pkg.sv]
// constants for the nibble cpu decode and addressing block
package ncda_pkg;

    // ------------------------------------------------------------
    // axi register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ncda_off_ctrl = 8'h00;   // bank/mode/clock control
    localparam logic [7:0] ncda_off_regs = 8'h04;   // register file image
    localparam logic [7:0] ncda_off_op = 8'h08;     // operand command
    localparam logic [7:0] ncda_off_pc = 8'h0c;     // program counter
    localparam logic [7:0] ncda_off_mem = 8'h10;    // data memory address result
    localparam logic [7:0] ncda_off_stat = 8'h14;   // status
    localparam logic [7:0] ncda_off_alt = 8'h18;    // expansion pair image

    // ctrl field positions
    localparam int ncda_ctrl_mbs_lsb = 0;   // 4 bits bank_select_reg
    localparam int ncda_ctrl_mbe = 4;       // bank_enable_flag
    localparam int ncda_ctrl_sbs_lsb = 8;   // 4 bits stack_bank_reg
    localparam int ncda_ctrl_pcc_lsb = 12;  // 2 bits cpu_clock_control_reg
    localparam int ncda_ctrl_rbe = 16;      // regbank_enable_flag
    localparam int ncda_ctrl_rbs_lsb = 17;  // 2 bits regbank_select_reg

    // reset values
    localparam logic [3:0] ncda_sbs_reset = 4'h8;   // basic compat mode
    localparam logic [3:0] ncda_mbs_reset = 4'h0;
    localparam int ncda_sbs_mode_bit = 3;

    // memory map
    localparam logic [11:0] ncda_disp_lo = 12'h1ec;
    localparam logic [11:0] ncda_disp_hi = 12'h1f7;
    localparam logic [11:0] ncda_periph_lo = 12'hf80;
    localparam logic [11:0] ncda_direct_lo_hi = 12'h07f;
    localparam logic [11:0] ncda_fmem_a_lo = 12'hfb0;
    localparam logic [11:0] ncda_fmem_b_lo = 12'hff0;
    localparam logic [7:0] ncda_taddr_lo = 8'h20;
    localparam logic [7:0] ncda_taddr_hi = 8'h7f;
    localparam logic [3:0] ncda_bank_periph = 4'hf;

    // relative branch reach
    localparam int ncda_rel_back_max = 15;
    localparam int ncda_rel_fwd_min = 2;
    localparam int ncda_rel_fwd_max = 16;

    // machine cycle dividers, in clock periods per cycle for each cycle time
    localparam logic [7:0] ncda_pcc_div0 = 8'h40;
    localparam logic [7:0] ncda_pcc_div1 = 8'h10;
    localparam logic [7:0] ncda_pcc_div2 = 8'h08;
    localparam logic [7:0] ncda_pcc_div3 = 8'h01;

    // operand commands
    typedef enum logic [4:0] {
        ncda_cmd_nop = 5'h00,
        ncda_cmd_direct = 5'h01,
        ncda_cmd_fmem = 5'h02,
        ncda_cmd_pmem = 5'h03,
        ncda_cmd_rel = 5'h04,
        ncda_cmd_page_branch = 5'h05,
        ncda_cmd_fast_call = 5'h06,
        ncda_cmd_table_indirect = 5'h07,
        ncda_cmd_long_branch = 5'h08,
        ncda_cmd_br_de = 5'h09,
        ncda_cmd_br_xa = 5'h0a,
        ncda_cmd_table_read = 5'h0b,
        ncda_cmd_rotate_carry = 5'h0c,
        ncda_cmd_add_with_carry = 5'h0d,
        ncda_cmd_ld_hl_inc = 5'h0e,
        ncda_cmd_pair_read = 5'h0f,
        ncda_cmd_skip = 5'h10,
        ncda_cmd_word_access = 5'h11
    } ncda_cmd_type;

    // axi responses
    localparam logic [1:0] ncda_resp_okay = 2'b00;
    localparam logic [1:0] ncda_resp_slverr = 2'b10;

endpackage : ncda_pkg
